// [logic/dnw_pkg.sv]
// Shared constants, types and helpers for the native write port, both ends.
package dnw_pkg;

  // ----------------------------------------------------------------
  // Widths and address layout
  // ----------------------------------------------------------------
  localparam int COL_W    = 10;
  localparam int BANK_W   = 3;
  localparam int ROW_W    = 14;
  localparam int ADDR_W   = COL_W + BANK_W + ROW_W;
  localparam int COL_LSB  = 0;
  localparam int BANK_LSB = COL_LSB + COL_W;
  localparam int ROW_LSB  = BANK_LSB + BANK_W;
  localparam int BURST_W  = 6;
  localparam int COUNT_W  = BURST_W + 1;
  localparam int DATA_W   = 64;
  localparam int MASK_W   = DATA_W / 8;

  // ----------------------------------------------------------------
  // Command queue timing
  // ----------------------------------------------------------------
  localparam int              QUEUE_DEPTH  = 4;
  localparam int              QPTR_W       = 2;
  localparam int              QCNT_W       = 3;
  localparam int              ISSUE_GAP    = 4;
  localparam logic [1:0]      ISSUE_RELOAD = 2'(ISSUE_GAP - 1);
  localparam logic [QCNT_W-1:0] QUEUE_FULL = QCNT_W'(QUEUE_DEPTH);

  typedef enum logic [1:0] {
    CMD_NONE      = 2'h0,
    CMD_ACTIVATE  = 2'h1,
    CMD_WRITE     = 2'h2,
    CMD_PRECHARGE = 2'h3
  } dnw_cmd_kind_t;

  typedef struct packed {
    dnw_cmd_kind_t    kind;
    logic [ROW_W-1:0] row;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
    logic             autoPre;
  } dnw_cmd_t;

  // Gray codes around the usual loop idle, activate, write, data and back to idle.
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_ACTIVATE  = 3'h1,
    ST_WRITE     = 3'h3,
    ST_DATA      = 3'h2,
    ST_PRECHARGE = 3'h4
  } dnw_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [ROW_W-1:0] addrRow(input logic [ADDR_W-1:0] a);
    return a[ROW_LSB +: ROW_W];
  endfunction

  function automatic logic [BANK_W-1:0] addrBank(input logic [ADDR_W-1:0] a);
    return a[BANK_LSB +: BANK_W];
  endfunction

  function automatic logic [COL_W-1:0] addrCol(input logic [ADDR_W-1:0] a);
    return a[COL_LSB +: COL_W];
  endfunction

  // A length of zero stands for 64 words, one more than the field can hold.
  function automatic logic [COUNT_W-1:0] burstWords(input logic [BURST_W-1:0] b);
    return (b == '0) ? COUNT_W'(1 << BURST_W) : {1'b0, b};
  endfunction

  // A set mask bit blanks its byte lane.
  function automatic logic [DATA_W-1:0] applyMask(input logic [DATA_W-1:0] d,
                                                   input logic [MASK_W-1:0] m);
    logic [DATA_W-1:0] r;
    r = d;
    for (int i = 0; i < MASK_W; i++) begin
      if (m[i]) begin
        r[i*8 +: 8] = 8'h00;
      end
    end
    return r;
  endfunction

endpackage

// [logic/dnw_if.sv]
// Native write request link between the requesting logic and the subsystem.
`timescale 1ns/10ps
interface dnw_if;
  logic                          writeReq;
  logic                          readReq;
  logic [dnw_pkg::ADDR_W-1:0]    addr;
  logic [dnw_pkg::BURST_W-1:0]   burstSize;
  logic                          auto_close_row;
  logic                          busy;
  logic                          dataPull;
  logic [dnw_pkg::DATA_W-1:0]    write_data_bus;
  logic [dnw_pkg::MASK_W-1:0]    write_byte_mask;

  modport device (
    input  writeReq,
    input  readReq,
    input  addr,
    input  burstSize,
    input  auto_close_row,
    output busy,
    output dataPull,
    input  write_data_bus,
    input  write_byte_mask
  );

  modport host (
    output writeReq,
    output readReq,
    output addr,
    output burstSize,
    output auto_close_row,
    input  busy,
    input  dataPull,
    output write_data_bus,
    output write_byte_mask
  );
endinterface // dnw_if

// [logic/dnw_device_end.sv]
// Subsystem end: accepts writes, plans row commands, queues and issues them, pulls data.
`timescale 1ns/10ps
module dnw_device_end (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  dnw_if.device                              link,
  output logic                               memCmdValid,
  output dnw_pkg::dnw_cmd_kind_t             memCmdKind,
  output logic [dnw_pkg::ROW_W-1:0]          memRow,
  output logic [dnw_pkg::BANK_W-1:0]         memBank,
  output logic [dnw_pkg::COL_W-1:0]          memCol,
  output logic                               memCsN,
  output logic                               memAutoPre,
  output logic                               memWrValid,
  output logic [dnw_pkg::DATA_W-1:0]         memWrData,
  output logic [dnw_pkg::MASK_W-1:0]         memWrMask
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dnw_pkg::dnw_state_t               state_q;
  dnw_pkg::dnw_state_t               state_d;
  logic                              busy_q;
  logic                              dataPull_q;
  logic                              dataPull_d;
  logic                              pullSeen_q;
  logic [dnw_pkg::COUNT_W-1:0]       pullsLeft_q;
  logic [dnw_pkg::ADDR_W-1:0]        reqAddr_q;
  logic [dnw_pkg::BURST_W-1:0]       reqBurst_q;
  logic                              reqAuto_q;
  logic                              openValid_q;
  logic [dnw_pkg::ROW_W-1:0]         openRow_q;
  logic [dnw_pkg::BANK_W-1:0]        openBank_q;
  dnw_pkg::dnw_cmd_t                 queue_q [dnw_pkg::QUEUE_DEPTH];
  logic [dnw_pkg::QPTR_W-1:0]        wrPtr_q;
  logic [dnw_pkg::QPTR_W-1:0]        rdPtr_q;
  logic [dnw_pkg::QCNT_W-1:0]        qCount_q;
  logic [1:0]                        issueTimer_q;
  logic                              accept;
  logic                              hitOpen;
  logic                              canEnq;
  logic                              enq;
  logic                              issue;
  dnw_pkg::dnw_cmd_t                 newCmd;

  assign link.busy     = busy_q;
  assign link.dataPull = dataPull_q;

  // ----------------------------------------------------------------
  // Request acceptance and planning
  // ----------------------------------------------------------------
  // The read request is never looked at here; the requester keeps the two apart.
  assign accept  = link.writeReq && !busy_q;
  assign hitOpen = openValid_q && (openRow_q == dnw_pkg::addrRow(link.addr))
                   && (openBank_q == dnw_pkg::addrBank(link.addr));
  assign canEnq  = qCount_q != dnw_pkg::QUEUE_FULL;
  assign enq     = canEnq && ((state_q == dnw_pkg::ST_PRECHARGE) || (state_q == dnw_pkg::ST_ACTIVATE)
                              || (state_q == dnw_pkg::ST_WRITE));
  assign issue   = (issueTimer_q == 2'h0) && (qCount_q != '0);
  assign dataPull_d = (state_q == dnw_pkg::ST_DATA) && (pullsLeft_q != '0);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dnw_pkg::ST_IDLE: begin
        if (accept) begin
          if (hitOpen) begin
            state_d = dnw_pkg::ST_WRITE;
          end else if (openValid_q) begin
            state_d = dnw_pkg::ST_PRECHARGE;
          end else begin
            state_d = dnw_pkg::ST_ACTIVATE;
          end
        end
      end
      dnw_pkg::ST_PRECHARGE: begin
        if (canEnq) begin
          state_d = dnw_pkg::ST_ACTIVATE;
        end
      end
      dnw_pkg::ST_ACTIVATE: begin
        if (canEnq) begin
          state_d = dnw_pkg::ST_WRITE;
        end
      end
      dnw_pkg::ST_WRITE: begin
        if (canEnq) begin
          state_d = dnw_pkg::ST_DATA;
        end
      end
      dnw_pkg::ST_DATA: begin
        if ((pullsLeft_q == '0) && !dataPull_q && !pullSeen_q) begin
          state_d = dnw_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = dnw_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    newCmd         = '0;
    newCmd.row     = dnw_pkg::addrRow(reqAddr_q);
    newCmd.bank    = dnw_pkg::addrBank(reqAddr_q);
    newCmd.col     = dnw_pkg::addrCol(reqAddr_q);
    newCmd.autoPre = 1'b0;
    unique case (state_q)
      dnw_pkg::ST_PRECHARGE: newCmd.kind = dnw_pkg::CMD_PRECHARGE;
      dnw_pkg::ST_ACTIVATE:  newCmd.kind = dnw_pkg::CMD_ACTIVATE;
      dnw_pkg::ST_WRITE: begin
        newCmd.kind    = dnw_pkg::CMD_WRITE;
        newCmd.autoPre = reqAuto_q;
      end
      default:               newCmd.kind = dnw_pkg::CMD_NONE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= dnw_pkg::ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= state_d != dnw_pkg::ST_IDLE;
    end
  end

  // Request fields are frozen while busy so the requester may move on early.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reqAddr_q  <= '0;
      reqBurst_q <= '0;
      reqAuto_q  <= 1'b0;
    end else if (accept) begin
      reqAddr_q  <= link.addr;
      reqBurst_q <= link.burstSize;
      reqAuto_q  <= link.auto_close_row;
    end
  end

  // One open row is tracked; any other bank or row forces a close first.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      openValid_q <= 1'b0;
      openRow_q   <= '0;
      openBank_q  <= '0;
    end else if (enq) begin
      if (newCmd.kind == dnw_pkg::CMD_PRECHARGE) begin
        openValid_q <= 1'b0;
      end else if (newCmd.kind == dnw_pkg::CMD_ACTIVATE) begin
        openValid_q <= 1'b1;
        openRow_q   <= newCmd.row;
        openBank_q  <= newCmd.bank;
      end else if (newCmd.autoPre) begin
        openValid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command queue
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < dnw_pkg::QUEUE_DEPTH; i++) begin
        queue_q[i] <= '0;
      end
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
      qCount_q <= '0;
    end else begin
      if (enq) begin
        queue_q[wrPtr_q] <= newCmd;
        wrPtr_q          <= wrPtr_q + 2'h1;
      end
      if (issue) begin
        rdPtr_q <= rdPtr_q + 2'h1;
      end
      if (enq && !issue) begin
        qCount_q <= qCount_q + 3'h1;
      end else if (issue && !enq) begin
        qCount_q <= qCount_q - 3'h1;
      end
    end
  end

  // The gap timer restarts on each issue, so back-to-back commands sit four cycles apart.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      issueTimer_q <= 2'h0;
    end else if (issue) begin
      issueTimer_q <= dnw_pkg::ISSUE_RELOAD;
    end else if (issueTimer_q != 2'h0) begin
      issueTimer_q <= issueTimer_q - 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      memCmdValid <= 1'b0;
      memCmdKind  <= dnw_pkg::CMD_NONE;
      memRow      <= '0;
      memBank     <= '0;
      memCol      <= '0;
      memCsN      <= 1'b1;
      memAutoPre  <= 1'b0;
    end else begin
      memCmdValid <= issue;
      memCmdKind  <= issue ? queue_q[rdPtr_q].kind : dnw_pkg::CMD_NONE;
      memRow      <= queue_q[rdPtr_q].row;
      memBank     <= queue_q[rdPtr_q].bank;
      memCol      <= queue_q[rdPtr_q].col;
      memCsN      <= !issue;
      memAutoPre  <= issue && queue_q[rdPtr_q].autoPre;
    end
  end

  // ----------------------------------------------------------------
  // Write data pull
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pullsLeft_q <= '0;
      dataPull_q  <= 1'b0;
      pullSeen_q  <= 1'b0;
    end else begin
      if ((state_q == dnw_pkg::ST_WRITE) && canEnq) begin
        pullsLeft_q <= dnw_pkg::burstWords(reqBurst_q);
      end else if (dataPull_d) begin
        pullsLeft_q <= pullsLeft_q - 7'h01;
      end
      dataPull_q <= dataPull_d;
      pullSeen_q <= dataPull_q;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      memWrValid <= 1'b0;
      memWrData  <= '0;
      memWrMask  <= '0;
    end else begin
      memWrValid <= pullSeen_q;
      if (pullSeen_q) begin
        memWrData <= dnw_pkg::applyMask(link.write_data_bus, link.write_byte_mask);
        memWrMask <= link.write_byte_mask;
      end
    end
  end

endmodule // dnw_device_end

// [logic/dnw_host_end.sv]
// Requester end: turns user write requests and data words into native link traffic.
`timescale 1ns/10ps
module dnw_host_end (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  dnw_if.host                              link,
  input  wire logic                        reqValid,
  input  wire logic [dnw_pkg::ADDR_W-1:0]  reqAddr,
  input  wire logic [dnw_pkg::BURST_W-1:0] reqBurst,
  input  wire logic                        reqAutoClose,
  output logic                             reqTaken,
  output logic                             reqAccepted,
  input  wire logic [dnw_pkg::DATA_W-1:0]  wordData,
  input  wire logic [dnw_pkg::MASK_W-1:0]  wordMask,
  output logic                             wordTaken
);

  // ----------------------------------------------------------------
  // Request holding
  // ----------------------------------------------------------------
  logic                            writeReq_q;
  logic [dnw_pkg::ADDR_W-1:0]      addr_q;
  logic [dnw_pkg::BURST_W-1:0]     burst_q;
  logic                            auto_q;
  logic                            readReq_q;
  logic [dnw_pkg::DATA_W-1:0]      data_q;
  logic [dnw_pkg::MASK_W-1:0]      mask_q;
  logic                            accepted;
  logic                            load;

  assign link.writeReq        = writeReq_q;
  assign link.readReq         = readReq_q;
  assign link.addr            = addr_q;
  assign link.burstSize       = burst_q;
  assign link.auto_close_row  = auto_q;
  assign link.write_data_bus  = data_q;
  assign link.write_byte_mask = mask_q;

  // Busy comes from a flop on the same clock, so no synchroniser is needed.
  assign accepted = writeReq_q && !link.busy;
  assign load     = (!writeReq_q || accepted) && reqValid;

  // No timing is assumed: the request simply waits for busy to fall.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      writeReq_q <= 1'b0;
      addr_q     <= '0;
      burst_q    <= '0;
      auto_q     <= 1'b0;
    end else if (load) begin
      writeReq_q <= 1'b1;
      addr_q     <= reqAddr;
      burst_q    <= reqBurst;
      auto_q     <= reqAutoClose;
    end else if (accepted) begin
      writeReq_q <= 1'b0;
    end
  end

  // This end only writes, so the read request stays low.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      readReq_q <= 1'b0;
    end else begin
      readReq_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reqTaken    <= 1'b0;
      reqAccepted <= 1'b0;
    end else begin
      reqTaken    <= load;
      reqAccepted <= accepted;
    end
  end

  // ----------------------------------------------------------------
  // Data supply
  // ----------------------------------------------------------------
  // The user must hold the next word ready; it is taken the edge the pull is seen.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_q    <= '0;
      mask_q    <= '0;
      wordTaken <= 1'b0;
    end else begin
      wordTaken <= link.dataPull;
      if (link.dataPull) begin
        data_q <= wordData;
        mask_q <= wordMask;
      end
    end
  end

endmodule // dnw_host_end

// [verif/dnw_link_monitor.sv]
// Concurrent checks on the native write link between the two ends.
`timescale 1ns/10ps
module dnw_link_monitor (
  input wire logic                        core_clk,
  input wire logic                        reset,
  input wire logic                        writeReq,
  input wire logic                        readReq,
  input wire logic [dnw_pkg::ADDR_W-1:0]  addr,
  input wire logic [dnw_pkg::BURST_W-1:0] burstSize,
  input wire logic                        auto_close_row,
  input wire logic                        busy,
  input wire logic                        dataPull
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_accept_then_busy: assert property (writeReq && !busy |=> busy[*3])
    else $error("busy did not hold after an accepted write");
  a_busy_needs_req: assert property ($rose(busy) |-> $past(writeReq))
    else $error("busy rose without a write request");
  a_refused_held: assert property (writeReq && busy |=> writeReq)
    else $error("refused write request was dropped");
  a_fields_stable: assert property (writeReq && busy |=> $stable(addr) && $stable(burstSize)
                                    && $stable(auto_close_row))
    else $error("request fields changed while refused");
  a_read_quiet: assert property (!readReq)
    else $error("read request raised on a write port");
  a_pull_in_busy: assert property (dataPull |-> busy)
    else $error("data pull outside a busy period");
  a_last_word_first: assert property ($fell(busy) |-> !$past(dataPull))
    else $error("busy fell before the last pulled word was taken");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:400] !busy)
    else $error("busy never fell");

  cover property (writeReq && !busy ##1 writeReq && busy);
  cover property (dataPull [*2]);
  cover property (auto_close_row && writeReq && !busy);
endmodule // dnw_link_monitor

// [verif/tb_top.sv]
// Self-checking bench joining both ends of the native write link.
`timescale 1ns/10ps
module tb_top;
  localparam time D = 2ns;
  logic                          core_clk, reset, reqValid, reqAutoClose;
  logic                          reqTaken, reqAccepted, wordTaken;
  logic [dnw_pkg::ADDR_W-1:0]    reqAddr;
  logic [dnw_pkg::BURST_W-1:0]   reqBurst;
  logic [dnw_pkg::DATA_W-1:0]    wordData, memWrData;
  logic [dnw_pkg::MASK_W-1:0]    wordMask, memWrMask;
  logic                          memCmdValid, memCsN, memAutoPre, memWrValid;
  dnw_pkg::dnw_cmd_kind_t        memCmdKind;
  logic [dnw_pkg::ROW_W-1:0]     memRow;
  logic [dnw_pkg::BANK_W-1:0]    memBank;
  logic [dnw_pkg::COL_W-1:0]     memCol;
  logic [29:0]                   cmdQ[$];
  int                            bad_count, n_compared, wIdx, wExp, cyc, lastCmd, acc;

  dnw_if i_dnw_if ();
  dnw_host_end i_dnw_host_end (.core_clk(core_clk), .reset(reset), .link(i_dnw_if), .reqValid(reqValid),
    .reqAddr(reqAddr), .reqBurst(reqBurst), .reqAutoClose(reqAutoClose), .reqTaken(reqTaken),
    .reqAccepted(reqAccepted), .wordData(wordData), .wordMask(wordMask), .wordTaken(wordTaken));
  dnw_device_end i_dnw_device_end (.core_clk(core_clk), .reset(reset), .link(i_dnw_if),
    .memCmdValid(memCmdValid), .memCmdKind(memCmdKind), .memRow(memRow), .memBank(memBank),
    .memCol(memCol), .memCsN(memCsN), .memAutoPre(memAutoPre), .memWrValid(memWrValid),
    .memWrData(memWrData), .memWrMask(memWrMask));
  dnw_link_monitor i_dnw_link_monitor (.core_clk(core_clk), .reset(reset), .writeReq(i_dnw_if.writeReq),
    .readReq(i_dnw_if.readReq), .addr(i_dnw_if.addr), .burstSize(i_dnw_if.burstSize),
    .auto_close_row(i_dnw_if.auto_close_row), .busy(i_dnw_if.busy), .dataPull(i_dnw_if.dataPull));

  // ----------------------------------------------------------------
  // Word source and expectations
  // ----------------------------------------------------------------
  function automatic logic [63:0] wd(int i);
    return {8{8'(i)}} ^ 64'h0123456789ABCDEF;
  endfunction
  function automatic logic [7:0] wm(int i);
    return 8'(i * 37);
  endfunction
  // Masked lanes must arrive as zero bytes.
  function automatic logic [63:0] wx(int i);
    logic [63:0] r;
    logic [7:0]  m;
    r = wd(i);
    m = wm(i);
    for (int b = 0; b < 8; b++) begin
      if (m[b]) r[b*8 +: 8] = 8'h00;
    end
    return r;
  endfunction
  function automatic logic [26:0] mk(logic [13:0] r, logic [2:0] bk, logic [9:0] c);
    return {r, bk, c};
  endfunction

  assign wordData = wd(wIdx);
  assign wordMask = wm(wIdx);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Observers
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (reqAccepted === 1'b1) acc++;
    if (memCmdValid === 1'b1) begin
      chk("chip_select", 64'h0, 64'(memCsN));
      chk("issue_gap", 64'h1, 64'(cyc - lastCmd >= 4));
      lastCmd = cyc;
      cmdQ.push_back({memCmdKind, memRow, memBank, memCol, memAutoPre});
    end
    if (memWrValid === 1'b1) begin
      chk("word_data", wx(wExp), memWrData);
      chk("word_mask", 64'(wm(wExp)), 64'(memWrMask));
      wExp++;
    end
  end

  always @(posedge core_clk) begin
    #D;
    if (wordTaken === 1'b1) wIdx++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic timed_out(string what);
    bad_count++;
    $display("[FAIL] %s expected done seen timeout", what);
    finish_test;
  endtask

  // Leaves reqValid high so a following call loads the next link request back to back.
  task automatic submit(logic [26:0] a, logic [5:0] b, logic ac);
    int n;
    n = 0;
    reqAddr = a;
    reqBurst = b;
    reqAutoClose = ac;
    reqValid = 1'b1;
    do begin
      @(posedge core_clk);
      #D;
      n++;
    end while (reqTaken !== 1'b1 && n < 200);
    if (n >= 200) timed_out("request_load");
  endtask

  task automatic wait_done(int nCmd, int nWords);
    int n;
    for (n = 0; n < 600 && (cmdQ.size() < nCmd || wExp < nWords); n++) begin
      @(posedge core_clk);
      #D;
    end
    if (n >= 600) timed_out("transfer");
    repeat (8) @(posedge core_clk);
    #D;
    chk("cmd_count", 64'(nCmd), 64'(cmdQ.size()));
    chk("word_count", 64'(nWords), 64'(wExp));
    chk("busy_idle", 64'h0, 64'(i_dnw_if.busy));
    chk("request_dropped", 64'h0, 64'(i_dnw_if.writeReq));
  endtask

  // Only the fields that a command kind carries are compared.
  task automatic expect_cmd(dnw_pkg::dnw_cmd_kind_t k, logic [13:0] r, logic [2:0] bk, logic [9:0] c,
                            logic ap);
    logic [29:0] e, m, g;
    e = {k, r, bk, c, ap};
    m = (k == dnw_pkg::CMD_ACTIVATE) ? {2'h3, 14'h3FFF, 3'h7, 10'h000, 1'h0} :
        (k == dnw_pkg::CMD_WRITE) ? 30'h3FFFFFFF : 30'h30000000;
    g = (cmdQ.size() > 0) ? cmdQ.pop_front() : 30'h0;
    chk("command", 64'(e & m), 64'(g & m));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_closed_row;
    submit(mk(14'h1234, 3'h2, 10'h010), 6'h02, 1'b0);
    reqValid = 1'b0;
    wait_done(2, 2);
    expect_cmd(dnw_pkg::CMD_ACTIVATE, 14'h1234, 3'h2, 10'h000, 1'b0);
    expect_cmd(dnw_pkg::CMD_WRITE, 14'h1234, 3'h2, 10'h010, 1'b0);
    $display("test closed_row done");
  endtask

  task automatic t_cascade;
    submit(mk(14'h1234, 3'h2, 10'h020), 6'h01, 1'b0);
    submit(mk(14'h1234, 3'h2, 10'h030), 6'h03, 1'b1);
    reqValid = 1'b0;
    wait_done(2, 6);
    expect_cmd(dnw_pkg::CMD_WRITE, 14'h1234, 3'h2, 10'h020, 1'b0);
    expect_cmd(dnw_pkg::CMD_WRITE, 14'h1234, 3'h2, 10'h030, 1'b1);
    chk("accepted", 64'h3, 64'(acc));
    $display("test cascade done");
  endtask

  task automatic t_reopen_miss;
    submit(mk(14'h1234, 3'h2, 10'h040), 6'h01, 1'b0);
    reqValid = 1'b0;
    wait_done(2, 7);
    expect_cmd(dnw_pkg::CMD_ACTIVATE, 14'h1234, 3'h2, 10'h000, 1'b0);
    expect_cmd(dnw_pkg::CMD_WRITE, 14'h1234, 3'h2, 10'h040, 1'b0);
    submit(mk(14'h0777, 3'h5, 10'h3FF), 6'h00, 1'b0);
    reqValid = 1'b0;
    wait_done(3, 71);
    expect_cmd(dnw_pkg::CMD_PRECHARGE, 14'h0000, 3'h0, 10'h000, 1'b0);
    expect_cmd(dnw_pkg::CMD_ACTIVATE, 14'h0777, 3'h5, 10'h000, 1'b0);
    expect_cmd(dnw_pkg::CMD_WRITE, 14'h0777, 3'h5, 10'h3FF, 1'b0);
    $display("test reopen_miss done");
  endtask

  initial begin
    reset = 1'b1;
    reqValid = 1'b0;
    reqAddr = '0;
    reqBurst = '0;
    reqAutoClose = 1'b0;
    bad_count = 0;
    n_compared = 0;
    wIdx = 0;
    wExp = 0;
    cyc = 0;
    lastCmd = -100;
    acc = 0;
    repeat (20) @(posedge core_clk);
    #D reset = 1'b0;
    t_closed_row;
    t_cascade;
    t_reopen_miss;
    finish_test;
  end
endmodule // tb_top
